// >>> src/pmwc_pkg.sv
package pmwc_pkg;

   // device operating modes
   typedef enum logic [3:0] {
      pmwc_run              = 4'h0,
      pmwc_vlp_run          = 4'h1,
      pmwc_wait             = 4'h3,
      pmwc_vlp_wait         = 4'h2,
      pmwc_stop             = 4'h6,
      pmwc_vlp_stop         = 4'h7,
      pmwc_ll_stop          = 4'h5,
      pmwc_leak_sram_kept   = 4'h4,
      pmwc_leak_regfile     = 4'hc,
      pmwc_leak_deepest     = 4'hd
   } pmwc_mode_type;

   // stop-type selection codes for the mode_ctrl stop select field
   localparam logic [2:0] STOP_SEL_STOP     = 3'h0;
   localparam logic [2:0] STOP_SEL_LP_STOP  = 3'h1;
   localparam logic [2:0] STOP_SEL_LL_STOP  = 3'h2;
   localparam logic [2:0] STOP_SEL_LEAK3    = 3'h3;
   localparam logic [2:0] STOP_SEL_LEAK1    = 3'h4;
   localparam logic [2:0] STOP_SEL_LEAK0    = 3'h5;

   localparam int    WAKE_PIN_COUNT      = 8;
   localparam int    WAKE_MOD_COUNT      = 8;
   localparam int    WAKE_MOD_TIMER      = 0;
   localparam int    WAKE_MOD_COMPARATOR = 1;
   localparam int    WAKE_MOD_ALARM      = 5;
   localparam int    WAKE_MOD_SECONDS    = 7;
   localparam logic [7:0] WAKE_MOD_USED  = 8'ha3;

   // avalon register map, word offsets as byte addresses
   localparam logic [3:0] REG_MODE_CTRL   = 4'h0;
   localparam logic [3:0] REG_MODE_STAT   = 4'h4;
   localparam logic [3:0] REG_WAKE_EN     = 4'h8;
   localparam logic [3:0] REG_WAKE_FLAGS  = 4'hc;

   // mode_ctrl fields
   localparam int CTRL_VLP_RUN_BIT    = 0;
   localparam int CTRL_SLEEPDEEP_BIT  = 1;
   localparam int CTRL_STOPSEL_LSB    = 2;
   localparam int CTRL_POR_DET_BIT    = 5;
   localparam int CTRL_SLOW_2M_BIT    = 6;
   localparam logic [6:0] CTRL_RESET  = 7'h00;
   localparam logic [15:0] WAKE_EN_RESET = 16'h0000;

   localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;

   // gate vector bit positions
   localparam int GATE_CORE       = 0;
   localparam int GATE_PERIPH     = 1;
   localparam int GATE_LV_MON     = 2;
   localparam int GATE_VIC        = 3;
   localparam int GATE_SRAM       = 4;
   localparam int GATE_REGFILE    = 5;
   localparam int GATE_COMPARATOR = 6;
   localparam int GATE_TIMER_RTC  = 7;
   localparam int GATE_PWR_CTRL   = 8;
   localparam int GATE_GPIO_HOLD  = 9;
   localparam int GATE_SLOW_OSC   = 10;
   localparam int GATE_KHZ_OSC    = 11;
   localparam int GATE_DMA_LP     = 12;
   localparam int GATE_REDUCED    = 13;
   localparam int GATE_WIDTH      = 14;

endpackage

// >>> src/pmwc_wake_unit.sv
`timescale 1ns/100ps
`default_nettype none
module pmwc_wake_unit
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        arm,
   input  wire logic        disarm,
   input  wire logic [15:0] enables,
   input  wire logic [15:0] sources,
   input  wire logic [15:0] ack,
   output logic             active,
   output logic [15:0]      flags,
   output logic             wake
);

   typedef struct packed
   {
      logic        active;
      logic [15:0] flags;
      logic        wake;
   } pmwc_wu_state_type;

   pmwc_wu_state_type st_ff;
   pmwc_wu_state_type nxt_st;

   always_comb
   begin
      nxt_st = st_ff;
      // inert unless a leakage stop armed it
      if (arm)
      begin
         nxt_st.active = 1'b1;
      end
      else if (disarm)
      begin
         nxt_st.active = 1'b0;
      end
      // a new event beats a same-cycle acknowledge
      nxt_st.flags = (st_ff.flags & ~ack) | (st_ff.active ? (sources & enables) : 16'h0000);
      nxt_st.wake  = st_ff.active && ((sources & enables) != 16'h0000);
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign active = st_ff.active;
   assign flags  = st_ff.flags;
   assign wake   = st_ff.wake;

endmodule
`default_nettype wire

// >>> src/pmwc_top.sv
// Notes on behaviour
// - sleep instruction picks wait or stop type
// - low power run: reduced clock, monitor off
// - wait: core sleeps, peripherals run
// - low power wait: reduced clock, monitor off
// - stop: retain all, few wakers, controller off
// - low power stop: sram kept, monitor off
// - leakage stop: sram, regfile, pins hold
// - very leakage stops: peripherals reset on wake
// - sram-kept variant: sram, regfile, comparator kept
// - regfile-only variant drops sram
// - deepest: power controller, regfile, timer/rtc, pin hold; por selectable
// - wake routed by mode family
// - wake unit armed only on entry to leakage modes
// - leakage stop exit disables wake unit
// - very leakage exit: detect until acknowledged
// - eight wake pins, four module sources
// - module sources 0,1,5,7; others reserved
// - slow oscillator 8/2 MHz, off in very leakage
// - kilohertz oscillator off only in deepest
// - very leakage wake raises system reset
`timescale 1ns/100ps
`default_nettype none
module pmwc_top
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        core_sleep_req,
   input  wire logic        vic_wake,
   input  wire logic        async_wake,
   input  wire logic [7:0]  wake_pins,
   input  wire logic        wake_src_timer_flag,
   input  wire logic        wake_src_comparator_flag,
   input  wire logic        wake_src_alarm_flag,
   input  wire logic        wake_src_seconds_flag,
   output logic [13:0]      domain_enable,
   output logic             slow_osc_2mhz,
   output logic             por_detect_enable,
   output logic             wake_system_reset
);

   typedef struct packed
   {
      pmwc_pkg::pmwc_mode_type mode;
      logic                    back_vlp;
      logic [6:0]              ctrl;
      logic [15:0]             wake_en;
      logic [15:0]             ack;
      logic                    arm;
      logic                    disarm;
      logic [7:0]              pin_meta;
      logic [7:0]              pin_sync;
      logic [3:0]              mod_meta;
      logic [3:0]              mod_sync;
      logic                    vic_meta;
      logic                    vic_sync;
      logic                    awk_meta;
      logic                    awk_sync;
      logic                    sleep_meta;
      logic                    sleep_sync;
      logic                    sleep_prev;
      logic [31:0]             rdata;
      logic                    ack_done;
      logic [13:0]             gates;
      logic                    osc2m;
      logic                    por_en;
      logic                    sys_reset;
   } pmwc_top_state_type;

   pmwc_top_state_type st_ff;
   pmwc_top_state_type nxt_st;

   logic        wu_active;
   logic [15:0] wu_flags;
   logic        wu_wake;
   logic [15:0] wu_sources;

   // the three variants that wake through a system reset
   function automatic logic is_leak(input pmwc_pkg::pmwc_mode_type m);
      is_leak = (m == pmwc_pkg::pmwc_leak_sram_kept) || (m == pmwc_pkg::pmwc_leak_regfile) ||
                (m == pmwc_pkg::pmwc_leak_deepest);
   endfunction

   function automatic logic [13:0] gates_of(input pmwc_pkg::pmwc_mode_type m);
      logic [13:0] g;
      g = '0;
      unique case (m)
         pmwc_pkg::pmwc_run:
         begin
            g = 14'h0fef;
         end
         pmwc_pkg::pmwc_vlp_run:
         begin
            g = 14'h0fef;
            g[pmwc_pkg::GATE_LV_MON]  = 1'b0;
            g[pmwc_pkg::GATE_REDUCED] = 1'b1;
         end
         pmwc_pkg::pmwc_wait:
         begin
            g = 14'h0fef;
            g[pmwc_pkg::GATE_CORE] = 1'b0;
         end
         pmwc_pkg::pmwc_vlp_wait:
         begin
            g = 14'h0fef;
            g[pmwc_pkg::GATE_CORE]    = 1'b0;
            g[pmwc_pkg::GATE_LV_MON]  = 1'b0;
            g[pmwc_pkg::GATE_REDUCED] = 1'b1;
         end
         pmwc_pkg::pmwc_stop:
         begin
            // monitor on, vic off, comparator and timer/rtc run
            g = 14'h0ff4;
         end
         pmwc_pkg::pmwc_vlp_stop:
         begin
            g = 14'h1ff0;
         end
         pmwc_pkg::pmwc_ll_stop:
         begin
            g = 14'h0ff0;
            g[pmwc_pkg::GATE_GPIO_HOLD] = 1'b1;
         end
         pmwc_pkg::pmwc_leak_sram_kept:
         begin
            g = 14'h0bf0;
         end
         pmwc_pkg::pmwc_leak_regfile:
         begin
            g = 14'h0be0;
         end
         pmwc_pkg::pmwc_leak_deepest:
         begin
            g = 14'h03a0;
         end
         default:
         begin
            g = 14'h0fef;
         end
      endcase
      // retained storage is never dropped outside the listed variants
      if (m != pmwc_pkg::pmwc_leak_regfile && m != pmwc_pkg::pmwc_leak_deepest)
      begin
         g[pmwc_pkg::GATE_SRAM] = 1'b1;
      end
      g[pmwc_pkg::GATE_REGFILE] = 1'b1;
      gates_of = g;
   endfunction

   // reserved module slots tied low so their flags never set
   assign wu_sources = {st_ff.mod_sync[3], 1'b0, st_ff.mod_sync[2], 3'b000,
                        st_ff.mod_sync[1], st_ff.mod_sync[0], st_ff.pin_sync};

   pmwc_wake_unit u_wake
   (
      .sys_clk (sys_clk),
      .rst     (rst),
      .arm     (st_ff.arm),
      .disarm  (st_ff.disarm),
      .enables (st_ff.wake_en),
      .sources (wu_sources),
      .ack     (st_ff.ack),
      .active  (wu_active),
      .flags   (wu_flags),
      .wake    (wu_wake)
   );

   always_comb
   begin
      logic                    sleep_edge;
      logic                    any_wake;
      pmwc_pkg::pmwc_mode_type sel_stop;
      logic [31:0]             be_mask;
      logic [31:0]             wr_val;
      sleep_edge = 1'b0;
      any_wake   = 1'b0;
      sel_stop   = pmwc_pkg::pmwc_stop;
      be_mask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
      wr_val     = avs_writedata & be_mask;
      nxt_st = st_ff;

      // two-flop synchronisers on all asynchronous pins
      nxt_st.pin_meta   = wake_pins;
      nxt_st.pin_sync   = st_ff.pin_meta;
      nxt_st.mod_meta   = {wake_src_seconds_flag, wake_src_alarm_flag, wake_src_comparator_flag, wake_src_timer_flag};
      nxt_st.mod_sync   = st_ff.mod_meta;
      nxt_st.vic_meta   = vic_wake;
      nxt_st.vic_sync   = st_ff.vic_meta;
      nxt_st.awk_meta   = async_wake;
      nxt_st.awk_sync   = st_ff.awk_meta;
      nxt_st.sleep_meta = core_sleep_req;
      nxt_st.sleep_sync = st_ff.sleep_meta;
      nxt_st.sleep_prev = st_ff.sleep_sync;
      sleep_edge        = st_ff.sleep_sync && !st_ff.sleep_prev;

      nxt_st.arm       = 1'b0;
      nxt_st.disarm    = 1'b0;
      nxt_st.ack       = '0;
      nxt_st.sys_reset = 1'b0;

      // spare select codes fall back to plain stop
      unique case (st_ff.ctrl[pmwc_pkg::CTRL_STOPSEL_LSB +: 3])
         pmwc_pkg::STOP_SEL_LP_STOP: sel_stop = pmwc_pkg::pmwc_vlp_stop;
         pmwc_pkg::STOP_SEL_LL_STOP: sel_stop = pmwc_pkg::pmwc_ll_stop;
         pmwc_pkg::STOP_SEL_LEAK3:   sel_stop = pmwc_pkg::pmwc_leak_sram_kept;
         pmwc_pkg::STOP_SEL_LEAK1:   sel_stop = pmwc_pkg::pmwc_leak_regfile;
         pmwc_pkg::STOP_SEL_LEAK0:   sel_stop = pmwc_pkg::pmwc_leak_deepest;
         default:                    sel_stop = pmwc_pkg::pmwc_stop;
      endcase

      // each family listens only to its own wake path
      unique case (st_ff.mode)
         pmwc_pkg::pmwc_run, pmwc_pkg::pmwc_vlp_run:
         begin
            nxt_st.mode = st_ff.ctrl[pmwc_pkg::CTRL_VLP_RUN_BIT] ? pmwc_pkg::pmwc_vlp_run : pmwc_pkg::pmwc_run;
            if (sleep_edge)
            begin
               // remember the run flavour the wake must restore
               nxt_st.back_vlp = (st_ff.mode == pmwc_pkg::pmwc_vlp_run);
               if (!st_ff.ctrl[pmwc_pkg::CTRL_SLEEPDEEP_BIT])
               begin
                  nxt_st.mode = (st_ff.mode == pmwc_pkg::pmwc_vlp_run) ? pmwc_pkg::pmwc_vlp_wait
                                                                       : pmwc_pkg::pmwc_wait;
               end
               else
               begin
                  // a fast-run core asking for low power stop falls back to plain stop
                  nxt_st.mode = (sel_stop == pmwc_pkg::pmwc_vlp_stop && st_ff.mode == pmwc_pkg::pmwc_run)
                                ? pmwc_pkg::pmwc_stop : sel_stop;
                  if (sel_stop == pmwc_pkg::pmwc_ll_stop || is_leak(sel_stop))
                  begin
                     nxt_st.arm = 1'b1;
                  end
               end
            end
         end
         pmwc_pkg::pmwc_wait, pmwc_pkg::pmwc_vlp_wait:
         begin
            any_wake = st_ff.vic_sync;
         end
         pmwc_pkg::pmwc_stop, pmwc_pkg::pmwc_vlp_stop:
         begin
            any_wake = st_ff.awk_sync;
         end
         pmwc_pkg::pmwc_ll_stop:
         begin
            any_wake = wu_wake;
            // no reset on this exit, so the unit simply stands down
            nxt_st.disarm = wu_wake;
         end
         pmwc_pkg::pmwc_leak_sram_kept, pmwc_pkg::pmwc_leak_regfile, pmwc_pkg::pmwc_leak_deepest:
         begin
            any_wake = wu_wake;
            nxt_st.sys_reset = wu_wake;
         end
         default:
         begin
            nxt_st.mode = pmwc_pkg::pmwc_run;
         end
      endcase

      if (any_wake)
      begin
         nxt_st.mode = st_ff.back_vlp ? pmwc_pkg::pmwc_vlp_run : pmwc_pkg::pmwc_run;
      end

      // wake unit stays armed after very leakage exit until software clears flags
      if (!is_leak(st_ff.mode) && st_ff.mode != pmwc_pkg::pmwc_ll_stop && wu_active && wu_flags == 16'h0000)
      begin
         nxt_st.disarm = 1'b1;
      end

      // avalon slave: answer one cycle after the request, waitrequest high meanwhile
      nxt_st.ack_done = 1'b0;
      if ((avs_read || avs_write) && !st_ff.ack_done)
      begin
         nxt_st.ack_done = 1'b1;
         nxt_st.rdata    = pmwc_pkg::BAD_ADDR_DATA;
         if (avs_read)
         begin
            unique case (avs_address)
               pmwc_pkg::REG_MODE_CTRL:  nxt_st.rdata = {25'h0, st_ff.ctrl};
               pmwc_pkg::REG_MODE_STAT:  nxt_st.rdata = {27'h0, wu_active, st_ff.mode};
               pmwc_pkg::REG_WAKE_EN:    nxt_st.rdata = {16'h0, st_ff.wake_en};
               pmwc_pkg::REG_WAKE_FLAGS: nxt_st.rdata = {16'h0, wu_flags};
               default:                  nxt_st.rdata = pmwc_pkg::BAD_ADDR_DATA;
            endcase
         end
      end

      // writes land only at the edge where waitrequest is seen low
      if (avs_write && st_ff.ack_done)
      begin
         unique case (avs_address)
            pmwc_pkg::REG_MODE_CTRL:  nxt_st.ctrl    = wr_val[6:0];
            pmwc_pkg::REG_WAKE_EN:    nxt_st.wake_en = wr_val[15:0] & {pmwc_pkg::WAKE_MOD_USED, 8'hff};
            pmwc_pkg::REG_WAKE_FLAGS: nxt_st.ack     = wr_val[15:0];
            default:                  nxt_st.ctrl    = st_ff.ctrl;
         endcase
      end

      // gates follow the next mode so they switch with it
      nxt_st.gates  = gates_of(nxt_st.mode);
      nxt_st.osc2m  = st_ff.ctrl[pmwc_pkg::CTRL_SLOW_2M_BIT];
      // por detect is only optional in the deepest variant
      nxt_st.por_en = (nxt_st.mode == pmwc_pkg::pmwc_leak_deepest) ? st_ff.ctrl[pmwc_pkg::CTRL_POR_DET_BIT]
                                                                  : 1'b1;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         // plain run with every domain but low power dma and reduced rate up
         st_ff         <= '0;
         st_ff.mode    <= pmwc_pkg::pmwc_run;
         st_ff.ctrl    <= pmwc_pkg::CTRL_RESET;
         st_ff.wake_en <= pmwc_pkg::WAKE_EN_RESET;
         st_ff.gates   <= 14'h0fff;
         st_ff.por_en  <= 1'b1;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign avs_readdata      = st_ff.rdata;
   assign avs_waitrequest   = !st_ff.ack_done;
   assign domain_enable     = st_ff.gates;
   assign slow_osc_2mhz     = st_ff.osc2m;
   assign por_detect_enable = st_ff.por_en;
   assign wake_system_reset = st_ff.sys_reset;

endmodule
`default_nettype wire

// >>> testbench/pmwc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module pmwc_core_model
(
   input  wire logic sys_clk,
   output logic      core_sleep_req,
   output logic      vic_wake,
   output logic      async_wake,
   output logic [7:0] wake_pins,
   output logic [3:0] mod_flags
);
   initial
   begin
      core_sleep_req = 1'b0;
      vic_wake = 1'b0;
      async_wake = 1'b0;
      wake_pins = 8'h00;
      mod_flags = 4'h0;
   end

   // held high until the wake, so the edge is seen whatever the sync delay
   task automatic sleep_now();
      @(posedge sys_clk);
      core_sleep_req <= 1'b1;
   endtask

   // kind 0 vic, 1 async, 2 or 3 wake unit source idx
   task automatic wake_now(input logic [1:0] kind, input int idx);
      @(posedge sys_clk);
      case (kind)
         2'd0: vic_wake <= 1'b1;
         2'd1: async_wake <= 1'b1;
         default:
            if (idx < 8)
               wake_pins[idx] <= 1'b1;
            else
               mod_flags[idx-8] <= 1'b1;
      endcase
   endtask

   task automatic release_all();
      @(posedge sys_clk);
      core_sleep_req <= 1'b0;
      vic_wake <= 1'b0;
      async_wake <= 1'b0;
      wake_pins <= 8'h00;
      mod_flags <= 4'h0;
   endtask
endmodule
`default_nettype wire

// >>> testbench/pmwc_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module pmwc_top_monitor
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        core_sleep_req,
   input wire logic        vic_wake,
   input wire logic        async_wake,
   input wire logic [7:0]  wake_pins,
   input wire logic        wake_src_timer_flag,
   input wire logic        wake_src_comparator_flag,
   input wire logic        wake_src_alarm_flag,
   input wire logic        wake_src_seconds_flag,
   input wire logic [13:0] domain_enable,
   input wire logic        slow_osc_2mhz,
   input wire logic        por_detect_enable,
   input wire logic        wake_system_reset
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_answer: assert property (p_answer) else $error("bus request not answered next cycle");
   property p_one_low; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_one_low: assert property (p_one_low) else $error("waitrequest low longer than one cycle");
   property p_core_sleep; $fell(domain_enable[pmwc_pkg::GATE_CORE]) |-> core_sleep_req; endproperty
   a_core_sleep: assert property (p_core_sleep) else $error("core stopped without sleep");
   property p_reduced; domain_enable[pmwc_pkg::GATE_REDUCED] |-> !domain_enable[pmwc_pkg::GATE_LV_MON]; endproperty
   a_reduced: assert property (p_reduced) else $error("monitor on at reduced rate");
   property p_vic; !domain_enable[pmwc_pkg::GATE_VIC] |-> !domain_enable[pmwc_pkg::GATE_CORE]; endproperty
   a_vic: assert property (p_vic) else $error("vic off while core runs");
   property p_kept; domain_enable[pmwc_pkg::GATE_REGFILE] && domain_enable[pmwc_pkg::GATE_TIMER_RTC]; endproperty
   a_kept: assert property (p_kept) else $error("regfile or timer dropped");
   property p_osc; !domain_enable[pmwc_pkg::GATE_SRAM] |-> !domain_enable[pmwc_pkg::GATE_SLOW_OSC]; endproperty
   a_osc: assert property (p_osc) else $error("slow oscillator on in leakage stop");
   property p_khz; !domain_enable[pmwc_pkg::GATE_KHZ_OSC] |-> !domain_enable[pmwc_pkg::GATE_COMPARATOR]; endproperty
   a_khz: assert property (p_khz) else $error("comparator on in deepest stop");
   property p_pulse; wake_system_reset |=> !wake_system_reset[*2]; endproperty
   a_pulse: assert property (p_pulse) else $error("wake reset longer than one cycle");
   property p_back; wake_system_reset |-> ##[0:8] domain_enable[pmwc_pkg::GATE_CORE]; endproperty
   a_back: assert property (p_back) else $error("core not back after wake");
   property p_vic_wake;
      $rose(vic_wake) && !domain_enable[pmwc_pkg::GATE_CORE] && domain_enable[pmwc_pkg::GATE_VIC]
         |-> ##[1:8] domain_enable[pmwc_pkg::GATE_CORE];
   endproperty
   a_vic_wake: assert property (p_vic_wake) else $error("wait not left on vic wake");

   c_sleep: cover property ($fell(domain_enable[pmwc_pkg::GATE_CORE]));
   c_reset: cover property (wake_system_reset);
   c_por: cover property (!por_detect_enable);
endmodule
`default_nettype wire

bind pmwc_top pmwc_top_monitor pmwc_top_monitor_inst (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_sleep_req(core_sleep_req),
   .vic_wake(vic_wake), .async_wake(async_wake), .wake_pins(wake_pins), .wake_src_timer_flag(wake_src_timer_flag),
   .wake_src_comparator_flag(wake_src_comparator_flag), .wake_src_alarm_flag(wake_src_alarm_flag),
   .wake_src_seconds_flag(wake_src_seconds_flag), .domain_enable(domain_enable), .slow_osc_2mhz(slow_osc_2mhz),
   .por_detect_enable(por_detect_enable), .wake_system_reset(wake_system_reset));

// >>> testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   typedef struct packed {
      logic [6:0]  ctrl;
      logic [3:0]  mode;
      logic [1:0]  kind;
      logic [13:0] mask;
      logic [13:0] dexp;
   } pmwc_row_type;

   logic         sys_clk = 1'b0;
   logic         rst = 1'b1;
   logic [3:0]   avs_address = 4'h0;
   logic         avs_read = 1'b0;
   logic         avs_write = 1'b0;
   logic [31:0]  avs_writedata = 32'h0;
   logic [3:0]   avs_byteenable = 4'hf;
   logic [31:0]  avs_readdata;
   logic         avs_waitrequest;
   logic         core_sleep_req;
   logic         vic_wake;
   logic         async_wake;
   logic [7:0]   wake_pins;
   logic [3:0]   mod_flags;
   logic [13:0]  domain_enable;
   logic         slow_osc_2mhz;
   logic         por_detect_enable;
   logic         wake_system_reset;
   int           err_total = 0;
   int           check_count = 0;
   int           pulses = 0;
   logic [31:0]  exp_q [$];
   int           src_bit [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 13, 15};
   // kind: 0 vic wake, 1 async wake, 2 wake unit, 3 wake unit with system reset
   pmwc_row_type rows [10] = '{
      '{7'h00, 4'h3, 2'd0, 14'h087d, 14'h087c}, '{7'h01, 4'h2, 2'd0, 14'h287d, 14'h2878},
      '{7'h02, 4'h6, 2'd1, 14'h087d, 14'h0874}, '{7'h06, 4'h6, 2'd1, 14'h087d, 14'h0874},
      '{7'h07, 4'h7, 2'd1, 14'h087d, 14'h0870}, '{7'h0a, 4'h5, 2'd2, 14'h0af1, 14'h0af0},
      '{7'h0e, 4'h4, 2'd3, 14'h0ff1, 14'h0bf0}, '{7'h12, 4'hc, 2'd3, 14'h0ff1, 14'h0be0},
      '{7'h16, 4'hd, 2'd3, 14'h0ff1, 14'h03a0}, '{7'h37, 4'hd, 2'd3, 14'h0ff1, 14'h03a0}};

   always #12.5 sys_clk = ~sys_clk;

   pmwc_top pmwc_top_inst (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_sleep_req(core_sleep_req),
      .vic_wake(vic_wake), .async_wake(async_wake), .wake_pins(wake_pins), .wake_src_timer_flag(mod_flags[0]),
      .wake_src_comparator_flag(mod_flags[1]), .wake_src_alarm_flag(mod_flags[2]),
      .wake_src_seconds_flag(mod_flags[3]), .domain_enable(domain_enable), .slow_osc_2mhz(slow_osc_2mhz),
      .por_detect_enable(por_detect_enable), .wake_system_reset(wake_system_reset));

   pmwc_core_model pmwc_core_model_inst (.sys_clk(sys_clk), .core_sleep_req(core_sleep_req),
      .vic_wake(vic_wake), .async_wake(async_wake), .wake_pins(wake_pins), .mod_flags(mod_flags));

   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // starts one edge late so a released strobe is never raised in the same step
   task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] data, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address <= addr;
      avs_writedata <= data;
      avs_byteenable <= be;
      avs_read <= ~wr;
      avs_write <= wr;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 40);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      check_val("bus answer", 32'h0, {31'h0, avs_waitrequest});
   endtask

   task automatic rd(input logic [3:0] addr, input logic [31:0] exp);
      exp_q.push_back(exp);
      bus(1'b0, addr, 32'h0, 4'hf);
   endtask

   task automatic wait_core(input logic v);
      int n;
      n = 0;
      while (domain_enable[pmwc_pkg::GATE_CORE] !== v && n < 20)
      begin
         @(posedge sys_clk);
         n++;
      end
      check_val("core clock", {31'h0, v}, {31'h0, domain_enable[pmwc_pkg::GATE_CORE]});
   endtask

   always @(posedge sys_clk)
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
         check_val("readdata", exp_q.pop_front(), avs_readdata);

   always @(posedge sys_clk)
      if (wake_system_reset === 1'b1)
         pulses <= pulses + 1;

   initial
   begin
      #750000;
      err_total++;
      close_out();
   end

   initial
   begin
      int           src;
      int           p0;
      pmwc_row_type r;
      void'($urandom(32'h9a2bf3e5));
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      check_val("domains", 32'h0fff, {18'h0, domain_enable});
      check_val("por", 32'h1, {31'h0, por_detect_enable});
      rd(pmwc_pkg::REG_MODE_CTRL, 32'h0);
      rd(pmwc_pkg::REG_MODE_STAT, 32'h0);
      rd(pmwc_pkg::REG_WAKE_FLAGS, 32'h0);
      rd(4'h2, 32'h0);
      bus(1'b1, pmwc_pkg::REG_WAKE_EN, 32'hffff_ffff, 4'h1);
      rd(pmwc_pkg::REG_WAKE_EN, 32'h0000_00ff);
      bus(1'b1, pmwc_pkg::REG_WAKE_EN, 32'hffff_ffff, 4'hf);
      rd(pmwc_pkg::REG_WAKE_EN, 32'h0000_a3ff);
      bus(1'b1, pmwc_pkg::REG_MODE_CTRL, 32'h0000_0040, 4'hf);
      rd(pmwc_pkg::REG_MODE_CTRL, 32'h0000_0040);
      check_val("slow osc", 32'h1, {31'h0, slow_osc_2mhz});
      foreach (rows[i])
      begin
         r = rows[i];
         src = $urandom_range(11);
         bus(1'b1, pmwc_pkg::REG_WAKE_EN, 32'h1 << src_bit[src], 4'hf);
         bus(1'b1, pmwc_pkg::REG_MODE_CTRL, {25'h0, r.ctrl}, 4'hf);
         pmwc_core_model_inst.sleep_now();
         wait_core(1'b0);
         check_val("domains", {18'h0, r.dexp}, {18'h0, domain_enable & r.mask});
         check_val("por", {31'h0, r.mode == 4'hd ? r.ctrl[5] : 1'b1}, {31'h0, por_detect_enable});
         rd(pmwc_pkg::REG_MODE_STAT, {27'h0, r.kind[1], r.mode});
         p0 = pulses;
         pmwc_core_model_inst.wake_now(r.kind, src);
         wait_core(1'b1);
         pmwc_core_model_inst.release_all();
         check_val("run domains", r.ctrl[0] ? 32'h2001 : 32'h0005, {18'h0, domain_enable & 14'h2005});
         rd(pmwc_pkg::REG_MODE_STAT, {27'h0, r.kind == 2'd3, 3'h0, r.ctrl[0]});
         check_val("reset pulses", 32'(p0 + (r.kind == 2'd3)), 32'(pulses));
         if (r.kind[1])
            rd(pmwc_pkg::REG_WAKE_FLAGS, 32'h1 << src_bit[src]);
         bus(1'b1, pmwc_pkg::REG_WAKE_FLAGS, 32'h1 << src_bit[src], 4'hf);
         // flags clear, then disarm, then active drops: three edges
         repeat (3) @(posedge sys_clk);
         rd(pmwc_pkg::REG_MODE_STAT, {28'h0, 3'h0, r.ctrl[0]});
      end
      close_out();
   end
endmodule
`default_nettype wire
